// file: logic/fatc_pkg.sv
// Purpose: constants shared by the fabric arbitration and timeout block
// Assumes: four ingress ports, four egress destinations, 32-bit APB
// Notes:   control field positions are little-endian bit numbers

package fatc_pkg;

   // =================================================================
   // geometry
   localparam int NP     = 4;
   localparam int PW     = 2;
   localparam int PRW    = 2;
   localparam int AGE_W  = 8;
   localparam int OVT_W  = 4;
   localparam int PER_W  = 16;
   localparam int PER_SH = 15;
   localparam int TMR_W  = PER_W + PER_SH;

   // =================================================================
   // register map
   localparam logic [31:0] CTRL_ADDR = 32'h0001aa00;
   localparam logic [31:0] STAT_ADDR = 32'h0001aa10;
   localparam logic [31:0] MASK_ADDR = 32'h0001aa14;

   localparam logic [31:0] CTRL_RESET = 32'h0f010200;
   localparam logic [31:0] CTRL_WMASK = 32'h0fb3ffff;

   localparam int OVT_MAX_LSB = 24;
   localparam int BOUND_BIT   = 23;
   localparam int ARB_LSB     = 20;
   localparam int IRQON_BIT   = 17;
   localparam int TMRON_BIT   = 16;
   localparam int PERIOD_LSB  = 0;

   typedef enum logic [1:0] {
      ARB_FCFS,
      ARB_SP1,
      ARB_RSVD,
      ARB_SP2
   } fatc_arb_type;

endpackage : fatc_pkg

// file: logic/fatc_req_slot.sv
// Purpose: one queued request of an ingress port with its timeout timer
// Assumes: load only while free_q is high
// Notes:   a grant in the timeout cycle wins, the request completes

`timescale 1ns/1ps
`default_nettype none

module fatc_req_slot
   import fatc_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               load,
   input  wire logic [PW-1:0]      dest_in,
   input  wire logic [PRW-1:0]     prio_in,
   input  wire logic               grant,
   input  wire logic               overtaken,
   input  wire logic               timer_live,
   input  wire logic [PER_W-1:0]   period,
   input  wire logic               bound_on,
   input  wire logic [OVT_W-1:0]   ovt_max,
   output logic                    valid_q,
   output logic                    free_q,
   output logic [PW-1:0]           dest_q,
   output logic [PRW-1:0]          prio_q,
   output logic [AGE_W-1:0]        age_q,
   output logic [OVT_W-1:0]        ovt_q,
   output logic                    err_q
);

   // =================================================================
   // timer
   logic [TMR_W-1:0] cnt_q;
   logic [TMR_W-1:0] limit;
   logic             expire;

   assign limit  = {period, {PER_SH{1'b0}}};
   assign expire = valid_q && timer_live && !grant &&
                   (cnt_q == limit - TMR_W'(1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (load || !valid_q || !timer_live) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + TMR_W'(1);
      end
   end

   // =================================================================
   // request holding
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_q <= 1'b0;
         free_q  <= 1'b1;
         dest_q  <= '0;
         prio_q  <= '0;
      end else if (load) begin
         valid_q <= 1'b1;
         free_q  <= 1'b0;
         dest_q  <= dest_in;
         prio_q  <= prio_in;
      end else if (grant || expire) begin
         valid_q <= 1'b0;
         free_q  <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
      end else begin
         err_q <= expire;
      end
   end

   // age breaks ties for first-come order
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_q <= '0;
         ovt_q <= '0;
      end else if (load) begin
         age_q <= '0;
         ovt_q <= '0;
      end else if (valid_q) begin
         if (age_q != '1) begin
            age_q <= age_q + AGE_W'(1);
         end
         if (overtaken && !(bound_on && ovt_q >= ovt_max) &&
             ovt_q != '1) begin
            ovt_q <= ovt_q + OVT_W'(1);
         end
      end
   end

   // =================================================================
   // checks
   chk_drop_on_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      err_q |-> !valid_q && $past(valid_q))
      else $error("timed-out request still queued");

   chk_timer_count: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(err_q) |-> $past(cnt_q) == $past(limit) - TMR_W'(1))
      else $error("timeout fired at wrong count");

endmodule : fatc_req_slot

`default_nettype wire

// file: logic/fatc_irq_regs.sv
// Purpose: sticky error status, mask and interrupt level
// Assumes: set pulses come from the same clock
// Notes:   a set in the clearing cycle wins over the clear

`timescale 1ns/1ps
`default_nettype none

module fatc_irq_regs
   import fatc_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic [NP-1:0]  set_ev,
   input  wire logic           wr_stat,
   input  wire logic           wr_mask,
   input  wire logic [NP-1:0]  wdata,
   input  wire logic           irq_on,
   output logic [NP-1:0]       stat_q,
   output logic [NP-1:0]       mask_q,
   output logic                irq_q
);

   logic [NP-1:0] stat_d;

   assign stat_d = (stat_q & ~(wr_stat ? wdata : '0)) | set_ev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else begin
         stat_q <= stat_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= '0;
      end else if (wr_mask) begin
         mask_q <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_on && |(stat_d & mask_q);
      end
   end

endmodule : fatc_irq_regs

`default_nettype wire

// file: logic/fatc_core.sv
// Purpose: fabric ingress arbitration, overtake bound and request timeout
// Assumes: ingress and egress logic share pclk; APB register access
// Notes:   one queued request per ingress port; grants are one-cycle pulses
//
// Local design decision: the APB interface to the registers.

`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - raise error acknowledge when a blocked request times out
// - drop timed-out request; source treats it incomplete
// - report each error by port-write, interrupt or both; port-write is always sent, interrupt only when enabled
// - reorder by priority or around a blocked head
// - bound enable, zero unbounded, resets to zero
// - two-bit arbitration scheme field, resets to zero
// - interrupt enable gates error interrupts, resets zero
// - timer enable, zero disables timer, resets one
// - timeout equals period field times two to fifteen
// - period field resets to 0x0200, software writable
// - zero period disables the timer
module fatc_core
   import fatc_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [NP-1:0]       req_valid,
   input  wire logic [NP*PW-1:0]    req_dest,
   input  wire logic [NP*PRW-1:0]   req_prio,
   output logic      [NP-1:0]       req_ready,
   output logic      [NP-1:0]       req_done,
   output logic      [NP-1:0]       blocked_request_error_ack,
   input  wire logic [NP-1:0]       dest_ready,
   output logic      [NP-1:0]       grant_valid,
   output logic      [NP*PW-1:0]    grant_src,
   output logic                     pw_valid,
   output logic      [NP-1:0]       pw_ports,
   output logic                     irq
);

   // =================================================================
   // control register
   logic [31:0]         fabric_control_q;
   logic [OVT_W-1:0]    overtake_count_max;
   logic                overtake_bound_on;
   fatc_arb_type        ingress_arbitration_scheme;
   logic                blocked_error_irq_on;
   logic                request_timer_on;
   logic [PER_W-1:0]    request_timeout_period;
   logic                timer_live;

   assign overtake_count_max =
      fabric_control_q[OVT_MAX_LSB +: OVT_W];
   assign overtake_bound_on = fabric_control_q[BOUND_BIT];
   assign ingress_arbitration_scheme =
      fatc_arb_type'(fabric_control_q[ARB_LSB +: 2]);
   assign blocked_error_irq_on = fabric_control_q[IRQON_BIT];
   assign request_timer_on     = fabric_control_q[TMRON_BIT];
   assign request_timeout_period =
      fabric_control_q[PERIOD_LSB +: PER_W];
   // a zero period means off, whatever the enable says
   assign timer_live = request_timer_on &&
                       (request_timeout_period != '0);

   // =================================================================
   // apb slave, zero wait states
   logic          acc;
   logic          hit_ctrl;
   logic          hit_stat;
   logic          hit_mask;
   logic [NP-1:0] stat_q;
   logic [NP-1:0] mask_q;

   assign acc      = psel && penable && pready;
   assign hit_ctrl = (paddr == CTRL_ADDR);
   assign hit_stat = (paddr == STAT_ADDR);
   assign hit_mask = (paddr == MASK_ADDR);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(hit_ctrl || hit_stat || hit_mask);
         if (psel && !penable && !pwrite) begin
            prdata <= hit_ctrl ? (fabric_control_q & CTRL_WMASK) :
                      hit_stat ? {{(32-NP){1'b0}}, stat_q} :
                      hit_mask ? {{(32-NP){1'b0}}, mask_q} : '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fabric_control_q <= CTRL_RESET;
      end else if (acc && pwrite && hit_ctrl) begin
         fabric_control_q <= pwdata & CTRL_WMASK;
      end
   end

   // =================================================================
   // request slots
   logic [NP-1:0]    s_valid;
   logic [NP-1:0]    s_free;
   logic [NP-1:0]    s_err;
   logic [NP-1:0]    s_load;
   logic [NP-1:0]    granted;
   logic [NP-1:0]    overtk;
   logic [PW-1:0]    s_dest [NP];
   logic [PRW-1:0]   s_prio [NP];
   logic [AGE_W-1:0] s_age  [NP];
   logic [OVT_W-1:0] s_ovt  [NP];

   // the port hands requests over in arrival order, one at a time
   assign s_load    = req_valid & s_free;
   assign req_ready = s_free;

   for (genvar g = 0; g < NP; g++) begin : g_slot
      fatc_req_slot u_slot (
         .pclk       (pclk),
         .presetn    (presetn),
         .load       (s_load[g]),
         .dest_in    (req_dest[g*PW +: PW]),
         .prio_in    (req_prio[g*PRW +: PRW]),
         .grant      (granted[g]),
         .overtaken  (overtk[g]),
         .timer_live (timer_live),
         .period     (request_timeout_period),
         .bound_on   (overtake_bound_on),
         .ovt_max    (overtake_count_max),
         .valid_q    (s_valid[g]),
         .free_q     (s_free[g]),
         .dest_q     (s_dest[g]),
         .prio_q     (s_prio[g]),
         .age_q      (s_age[g]),
         .ovt_q      (s_ovt[g]),
         .err_q      (s_err[g])
      );
   end

   assign blocked_request_error_ack = s_err;

   // =================================================================
   // arbitration
   function automatic logic starved(input logic on,
                                    input logic [OVT_W-1:0] cnt,
                                    input logic [OVT_W-1:0] lim);
      starved = on && (cnt >= lim);
   endfunction : starved

   logic [NP-1:0]    cand;
   logic [NP-1:0]    gv_d;
   logic [NP*PW-1:0] gs_d;
   logic             have;
   logic             better;
   logic [PW-1:0]    best;

   always_comb begin
      gv_d    = '0;
      gs_d    = '0;
      granted = '0;
      overtk  = '0;
      cand    = '0;
      have    = 1'b0;
      better  = 1'b0;
      best    = '0;
      for (int d = 0; d < NP; d++) begin
         have = 1'b0;
         best = '0;
         for (int p = 0; p < NP; p++) begin
            cand[p] = s_valid[p] && (s_dest[p] == PW'(d));
            // an older starved packet of equal or higher priority holds
            // back the others, bounding its latency
            for (int s = 0; s < NP; s++) begin
               if (s != p && s_valid[s] &&
                   starved(overtake_bound_on, s_ovt[s],
                           overtake_count_max) &&
                   s_prio[s] >= s_prio[p] &&
                   s_age[s] > s_age[p]) begin
                  cand[p] = 1'b0;
               end
            end
            case (ingress_arbitration_scheme)
               ARB_SP1: better = s_prio[p] > s_prio[best] ||
                                 (s_prio[p] == s_prio[best] &&
                                  s_age[p] > s_age[best]);
               ARB_SP2: better = s_prio[p] > s_prio[best];
               default: better = s_age[p] > s_age[best];
            endcase
            if (cand[p] && (!have || better)) begin
               have = 1'b1;
               best = PW'(p);
            end
         end
         if (have && dest_ready[d]) begin
            gv_d[d]           = 1'b1;
            gs_d[d*PW +: PW]  = best;
            granted[best]     = 1'b1;
         end
      end
      for (int s = 0; s < NP; s++) begin
         for (int p = 0; p < NP; p++) begin
            if (granted[p] && p != s && s_valid[s] && !granted[s] &&
                s_prio[p] <= s_prio[s] && s_age[p] < s_age[s]) begin
               overtk[s] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grant_valid <= '0;
         grant_src   <= '0;
         req_done    <= '0;
      end else begin
         grant_valid <= gv_d;
         grant_src   <= gs_d;
         req_done    <= granted;
      end
   end

   // =================================================================
   // error reporting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_valid <= 1'b0;
         pw_ports <= '0;
      end else begin
         pw_valid <= |s_err;
         pw_ports <= s_err;
      end
   end

   fatc_irq_regs u_irq (
      .pclk    (pclk),
      .presetn (presetn),
      .set_ev  (s_err),
      .wr_stat (acc && pwrite && hit_stat),
      .wr_mask (acc && pwrite && hit_mask),
      .wdata   (pwdata[NP-1:0]),
      .irq_on  (blocked_error_irq_on),
      .stat_q  (stat_q),
      .mask_q  (mask_q),
      .irq_q   (irq)
   );

   // =================================================================
   // checks
   chk_irq_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      irq |-> $past(blocked_error_irq_on) &&
              (stat_q & $past(mask_q)) != '0)
      else $error("interrupt without enable or status");

   chk_error_report: assert property (
      @(posedge pclk) disable iff (!presetn)
      (s_err != '0) |=> pw_valid && pw_ports == $past(s_err))
      else $error("error acknowledge not reported");

   chk_reserved_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fabric_control_q & ~CTRL_WMASK) == '0)
      else $error("reserved control bit set");

   chk_timer_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      !timer_live [*2] |=> blocked_request_error_ack == '0)
      else $error("timeout while timer disabled");

   chk_grant_ready: assert property (
      @(posedge pclk) disable iff (!presetn)
      grant_valid != '0 |-> (grant_valid & ~$past(dest_ready)) == '0)
      else $error("grant to a blocked destination");

   chk_done_not_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      (req_done & blocked_request_error_ack) == '0)
      else $error("request both completed and failed");

   chk_ready_after_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      blocked_request_error_ack[0] |-> req_ready[0])
      else $error("error raised but slot not freed");

endmodule : fatc_core

`default_nettype wire

// file: verif/fatc_port_model.sv
// Purpose: ingress sources and egress destinations facing the fabric
// Assumes: go is a one-cycle strobe, one request per port
// Notes:   idle request fields show the inverse of their last value

`timescale 1ns/1ps
`default_nettype none

module fatc_port_model
   import fatc_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [NP-1:0]     go,
   input  wire logic [NP*PW-1:0]  go_dest,
   input  wire logic [NP*PRW-1:0] go_prio,
   input  wire logic [NP-1:0]     blk,
   input  wire logic [NP-1:0]     req_ready,
   output logic      [NP-1:0]     req_valid,
   output logic      [NP*PW-1:0]  req_dest,
   output logic      [NP*PRW-1:0] req_prio,
   output logic      [NP-1:0]     dest_ready
);
   // =================================================================
   // egress: a blocked destination is the slow answer
   assign dest_ready = ~blk;

   // =================================================================
   // ingress: offer held until taken, never reordered, no retry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_valid <= '0;
         req_dest  <= '0;
         req_prio  <= '0;
      end else begin
         for (int p = 0; p < NP; p++) begin
            if (req_valid[p] && req_ready[p]) begin
               req_valid[p]           <= 1'b0;
               req_dest[p*PW +: PW]   <= ~req_dest[p*PW +: PW];
               req_prio[p*PRW +: PRW] <= ~req_prio[p*PRW +: PRW];
            end else if (go[p] && !req_valid[p]) begin
               req_valid[p]           <= 1'b1;
               req_dest[p*PW +: PW]   <= go_dest[p*PW +: PW];
               req_prio[p*PRW +: PRW] <= go_prio[p*PRW +: PRW];
            end
         end
      end
   end
endmodule : fatc_port_model

`default_nettype wire

// file: verif/fabric_arbitration_timeout_ctl_tb.sv
// Purpose: self-checking bench for fabric arbitration and timeout
// Assumes: zero-wait APB slave, port model on the fabric side
// Notes:   three waits of one timer period dominate the run time

`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   miscompares++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module fabric_arbitration_timeout_ctl_tb
   import fatc_pkg::*;
;
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [31:0]       paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [NP-1:0]     req_valid;
   logic [NP*PW-1:0]  req_dest;
   logic [NP*PRW-1:0] req_prio;
   logic [NP-1:0]     req_ready;
   logic [NP-1:0]     req_done;
   logic [NP-1:0]     err_ack;
   logic [NP-1:0]     dest_ready;
   logic [NP-1:0]     grant_valid;
   logic [NP*PW-1:0]  grant_src;
   logic              pw_valid;
   logic [NP-1:0]     pw_ports;
   logic              irq;
   logic [NP-1:0]     go;
   logic [NP*PW-1:0]  go_dest;
   logic [NP*PRW-1:0] go_prio;
   logic [NP-1:0]     blk;
   logic [31:0]       rdat;
   logic              rerr;
   int                miscompares;
   int                n_compared;

   fatc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid(req_valid), .req_dest(req_dest), .req_prio(req_prio),
      .req_ready(req_ready), .req_done(req_done),
      .blocked_request_error_ack(err_ack), .dest_ready(dest_ready),
      .grant_valid(grant_valid), .grant_src(grant_src),
      .pw_valid(pw_valid), .pw_ports(pw_ports), .irq(irq));

   fatc_port_model i_model (.pclk(pclk), .presetn(presetn), .go(go),
      .go_dest(go_dest), .go_prio(go_prio), .blk(blk),
      .req_ready(req_ready), .req_valid(req_valid), .req_dest(req_dest),
      .req_prio(req_prio), .dest_ready(dest_ready));

   // =================================================================
   // tasks
   task results;
      if (miscompares == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   task bound_hit(input string nm);
      miscompares++;
      $display("[ERR] %s exp answer got timeout", nm);
      results();
   endtask : bound_hit

   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 32);
      if (k >= 32) bound_hit("pready");
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // returns at the edge where the request is taken
   task send(input int p, input logic [PW-1:0] d, input logic [PRW-1:0] r);
      int k;
      go[p]                 <= 1'b1;
      go_dest[p*PW +: PW]   <= d;
      go_prio[p*PRW +: PRW] <= r;
      @(posedge pclk);
      go[p] <= 1'b0;
      k = 0;
      while (!(req_valid[p] === 1'b1 && req_ready[p] === 1'b1) && k < 64) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 64) bound_hit("take");
   endtask : send

   task irq_is(input logic e);
      repeat (3) @(posedge pclk);
      `CHK("irq", e, irq)
   endtask : irq_is

   // =================================================================
   // clock and sequence
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   initial begin : main
      int         n;
      logic [3:0] seen;
      logic [1:0] expw [4];
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {go, go_dest, go_prio, blk} = '0;
      miscompares = 0;
      n_compared  = 0;
      presetn     = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, CTRL_ADDR, 0);
      `CHK("ctrl", CTRL_RESET, rdat)
      apb(0, STAT_ADDR, 0);
      `CHK("stat", 32'h0, rdat)
      apb(1, CTRL_ADDR, 32'hffffffff);
      apb(0, CTRL_ADDR, 0);
      `CHK("ctrl_ones", CTRL_WMASK, rdat)
      apb(1, CTRL_ADDR, 32'h0);
      apb(0, CTRL_ADDR, 0);
      `CHK("ctrl_zero", 32'h0, rdat)
      apb(0, 32'h0001aa0c, 0);
      `CHK("slverr", 1'b1, rerr)
      `CHK("bad_rd", 32'h0, rdat)
      // plain grant, two edges after take
      apb(1, CTRL_ADDR, 32'h00010001);
      send(0, 2'd1, 2'd0);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (req_done[0] !== 1'b1 && n < 16);
      `CHK("done_lat", 2, n)
      `CHK("grant", 1'b1, grant_valid[1])
      `CHK("src", 2'd0, grant_src[3:2])
      // first winner per scheme, queue held behind a blocked head
      expw = '{2'd2, 2'd3, 2'd2, 2'd1};
      for (int m = 0; m < 4; m++) begin
         apb(1, CTRL_ADDR, 32'h00010001 | (32'(m) << ARB_LSB));
         blk <= 4'h1;
         send(2, 2'd0, 2'd0);
         send(0, 2'd0, 2'd1);
         send(3, 2'd0, 2'd3);
         send(1, 2'd0, 2'd3);
         blk <= 4'h0;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (grant_valid[0] !== 1'b1 && n < 16);
         if (n >= 16) bound_hit("grant");
         `CHK("winner", expw[m], grant_src[1:0])
         n = 0;
         while (req_ready !== 4'hf && n < 64) begin
            @(posedge pclk);
            n++;
         end
      end
      // timeout of a blocked request, period one
      apb(1, MASK_ADDR, 32'h2);
      apb(1, CTRL_ADDR, 32'h00030001);
      blk <= 4'h4;
      send(1, 2'd2, 2'd0);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (err_ack[1] !== 1'b1 && n < 33000);
      // error flop loads at take plus 32768, seen one edge later
      `CHK("tmo_lat", 32769, n)
      `CHK("ready_back", 1'b1, req_ready[1])
      `CHK("no_done", 1'b0, req_done[1])
      // port-write flops follow the error flop by one edge
      @(posedge pclk);
      `CHK("pw", 1'b1, pw_valid)
      `CHK("pw_ports", 4'h2, pw_ports)
      blk  <= 4'h0;
      seen = '0;
      repeat (8) begin
         @(posedge pclk);
         seen = seen | grant_valid;
      end
      `CHK("dropped", 4'h0, seen)
      `CHK("irq_set", 1'b1, irq)
      apb(0, STAT_ADDR, 0);
      `CHK("stat_set", 32'h2, rdat)
      apb(1, CTRL_ADDR, 32'h00010001);
      irq_is(1'b0);
      apb(1, CTRL_ADDR, 32'h00030001);
      irq_is(1'b1);
      apb(1, MASK_ADDR, 32'h0);
      irq_is(1'b0);
      apb(1, MASK_ADDR, 32'h2);
      irq_is(1'b1);
      apb(1, STAT_ADDR, 32'h2);
      irq_is(1'b0);
      apb(0, STAT_ADDR, 0);
      `CHK("stat_clr", 32'h0, rdat)
      // zero period, then timer off, one request waits through both
      apb(1, CTRL_ADDR, 32'h00010000);
      blk <= 4'h8;
      send(2, 2'd3, 2'd0);
      seen = '0;
      repeat (32800) begin
         @(posedge pclk);
         seen = seen | err_ack;
      end
      `CHK("zero_period", 4'h0, seen)
      apb(1, CTRL_ADDR, 32'h00000001);
      seen = '0;
      repeat (32800) begin
         @(posedge pclk);
         seen = seen | err_ack;
      end
      `CHK("timer_off", 4'h0, seen)
      blk <= 4'h0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (req_done[2] !== 1'b1 && n < 16);
      `CHK("late_done", 1'b1, req_done[2])
      results();
   end
endmodule : fabric_arbitration_timeout_ctl_tb

`default_nettype wire
